// *** sim/mfr_bench.sv ***
/* Self-checking bench for mfr_top with host model and array model.
   Assumes a 50 ns core clock and a 400 ns serial clock. */
`timescale 1ns/1ps
`default_nettype none
module mfr_bench;
  import mfr_pkg::*;
  logic        clk;
  logic        arst_n;
  logic        sck;
  logic        cs_n;
  logic [3:0]  line;
  logic [3:0]  dout;
  logic [3:0]  doe;
  logic [3:0]  ho;
  logic [3:0]  hoe;
  logic        qe;
  logic        fw;
  logic        busy;
  mfr_load_t   load;
  logic        cmode;
  logic [1:0]  rparam;
  logic        tog = 1'b0;
  int          oe_hits = 0;
  logic [31:0] pick;
  logic [7:0]  mem [256];
  logic [31:0] seed = 32'h149F70CA;
  logic [31:0] cyc = 32'd0;
  int          err_total;
  int          comparisons;
  mfr_top mfr_top_i (.CORE_CLK(clk), .ARST_N(arst_n), .SCK(sck), .CS_N(cs_n), .DATA_IN(line),
    .DATA_OUT(dout), .DATA_OE(doe), .QUAD_ENABLE(qe), .FOUR_WIRE_MODE(fw), .BUSY(busy),
    .LOAD(load), .CONTINUOUS_MODE(cmode), .READ_PARAM(rparam));
  mfr_host mfr_host_i (.clk(clk), .line(line), .sck(sck), .cs_n(cs_n), .o(ho), .oe(hoe));
  // Released lines toggle, so a stale level never passes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line[i] = doe[i] ? dout[i] : (hoe[i] ? ho[i] : tog);
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    tog <= ~tog;
    cyc <= cyc + 32'd1;
    if (doe !== 4'h0) oe_hits <= oe_hits + 1;
    if (cyc == 32'd40000) begin
      err_total++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // ow 0 skips the opcode; ok 0 expects silence
  task automatic rd(input logic [7:0] op, input int ow, input int aw, input int mc,
                    input logic [7:0] md, input int dum, input int dw, input bit ok);
    logic [7:0]  a;
    logic [31:0] h;
    logic [31:0] r;
    int          hits0;
    a = 8'(rnd());
    h = rnd();
    mfr_host_i.sel(1);
    hits0 = oe_hits;
    if (ow != 0) mfr_host_i.send({op, 24'h0}, 8 / ow, ow, 1);
    mfr_host_i.send({h[15:0], a, 8'h00}, 24 / aw, aw, 1);
    if (mc != 0) mfr_host_i.send({md, 24'h0}, mc / 2, aw, 1);
    if (mc != 0) mfr_host_i.send({md[3:0], 28'h0}, mc / 2, aw, aw != 2);
    mfr_host_i.send(rnd(), dum, aw, 1);
    mfr_host_i.get(24 / dw, dw, r);
    mfr_host_i.sel(0);
    if (ok) chk(r[23:0], {mem[a], mem[8'(a + 1)], mem[8'(a + 2)]});
    else chk(24'(oe_hits - hits0), 24'h0);
  endtask : rd
  task automatic cmd(input logic [7:0] op, input int w, input logic [7:0] d, input bit nd);
    mfr_host_i.sel(1);
    mfr_host_i.send({op, 24'h0}, 8 / w, w, 1);
    if (nd) mfr_host_i.send({d, 24'h0}, 8 / w, w, 1);
    mfr_host_i.sel(0);
  endtask : cmd
  initial begin
    arst_n = 1'b0;
    {qe, fw, busy} = 3'b100;
    load = '0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({22'h0, rparam}, {22'h0, PARAM_DEFAULT});
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(rnd());
      load <= '{1'b1, 8'(i), mem[i]};
      @(posedge clk);
    end
    load <= '0;
    rd(OP_FAST_READ, 1, 1, 0, 8'h00, 8, 1, 1);
    rd(OP_DUAL_OUT, 1, 1, 0, 8'h00, 8, 2, 1);
    rd(OP_QUAD_OUT, 1, 1, 0, 8'h00, 8, 4, 1);
    // Random enable and busy levels between frames
    for (int k = 0; k < 4; k++) begin
      pick = rnd();
      qe   <= pick[0];
      busy <= pick[1];
      rd(OP_QUAD_OUT, 1, 1, 0, 8'h00, 8, 4, pick[0] && !pick[1]);
    end
    busy <= 1'b1;
    rd(OP_FAST_READ, 1, 1, 0, 8'h00, 8, 1, 0);
    busy <= 1'b0;
    qe <= 1'b0;
    rd(OP_QUAD_OUT, 1, 1, 0, 8'h00, 8, 4, 0);
    rd(OP_QUAD_IO, 1, 4, 2, 8'hA0, 4, 4, 0);
    qe <= 1'b1;
    rd(OP_DUAL_IO, 1, 2, 4, 8'h20, 0, 2, 1);
    chk({23'h0, cmode}, 24'h1);
    rd(8'h00, 0, 2, 4, 8'hA0, 0, 2, 1);
    mfr_host_i.sel(1);
    mfr_host_i.send(32'hFFFF0000, 16, 1, 1);
    mfr_host_i.sel(0);
    chk({23'h0, cmode}, 24'h0);
    rd(OP_QUAD_IO, 1, 4, 2, 8'hA5, 4, 4, 1);
    chk({23'h0, cmode}, 24'h1);
    // In continuous mode these frames are short address frames, never reaching the mode byte
    cmd(OP_RESET_EN, 4, 8'h00, 0);
    cmd(OP_RESET, 4, 8'h00, 0);
    chk({23'h0, cmode}, 24'h1);
    rd(8'h00, 0, 4, 2, 8'h25, 4, 4, 1);
    mfr_host_i.sel(1);
    mfr_host_i.send(32'hFF000000, 8, 1, 1);
    mfr_host_i.sel(0);
    chk({23'h0, cmode}, 24'h0);
    rd(OP_QUAD_IO, 1, 4, 2, 8'hF0, 4, 4, 1);
    chk({23'h0, cmode}, 24'h0);
    fw <= 1'b1;
    for (int p = 3; p >= 0; p--) begin
      cmd(OP_SET_PARAM, 4, {2'b00, 2'(p), 4'h0}, 1);
      chk({22'h0, rparam}, 24'(p));
      rd(OP_FAST_READ, 4, 4, 0, 8'h00, (p == 3) ? 8 : (p == 2) ? 6 : 4, 4, 1);
    end
    cmd(OP_SET_PARAM, 4, 8'h30, 1);
    cmd(OP_RESET_EN, 4, 8'h00, 0);
    cmd(OP_RESET, 4, 8'h00, 0);
    chk({22'h0, rparam}, {22'h0, PARAM_DEFAULT});
    cmd(OP_SET_PARAM, 4, 8'h20, 1);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({22'h0, rparam}, {22'h0, PARAM_DEFAULT});
    chk({23'h0, cmode}, 24'h0);
    fw <= 1'b0;
    rd(OP_FAST_READ, 1, 1, 0, 8'h00, 8, 1, 1);
    summarize();
  end
endmodule : mfr_bench
`default_nettype wire

// *** sim/mfr_host.sv ***
/* Host controller model: chip select, serial clock, host data drive.
   Assumes the bench resolves the shared wires into line. */
`timescale 1ns/1ps
`default_nettype none
module mfr_host (
  // Pacing clock
  input  wire logic       clk,
  // Link
  input  wire logic [3:0] line,
  output var  logic       sck,
  output var  logic       cs_n,
  output var  logic [3:0] o,
  output var  logic [3:0] oe
);
  logic [3:0] smp;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    o = 4'h0;
    oe = 4'h0;
  end
  // Clock rests low between frames
  task automatic tick();
    repeat (4) @(posedge clk);
    sck <= 1'b1;
    @(posedge clk);
    smp = line;
    repeat (3) @(posedge clk);
    sck <= 1'b0;
  endtask : tick
  task automatic sel(input bit on);
    @(posedge clk);
    cs_n <= !on;
    repeat (8) @(posedge clk);
  endtask : sel
  task automatic send(input logic [31:0] v, input int n, input int w, input bit drv);
    for (int i = 0; i < n; i++) begin
      o <= (w == 4) ? v[31:28] : (w == 2) ? {2'b00, v[31:30]} : {3'b000, v[31]};
      oe <= drv ? 4'((1 << w) - 1) : 4'h0;
      v = v << w;
      tick();
    end
  endtask : send
  task automatic get(input int n, input int w, output logic [31:0] r);
    oe <= 4'h0;
    r = 32'h0;
    for (int i = 0; i < n; i++) begin
      tick();
      r = (w == 4) ? {r[27:0], smp} : (w == 2) ? {r[29:0], smp[1:0]} : {r[30:0], smp[1]};
    end
  endtask : get
endmodule : mfr_host
`default_nettype wire

// *** sim/mfr_props.sv ***
/* Port checker for the fast read path, bound to mfr_top.
   Assumes frames are kept several core cycles apart. */
`timescale 1ns/1ps
`default_nettype none
module mfr_props (
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       ARST_N,
  // Link
  input wire logic       SCK,
  input wire logic       CS_N,
  input wire logic [3:0] DATA_OUT,
  input wire logic [3:0] DATA_OE,
  // Status
  input wire logic       QUAD_ENABLE,
  input wire logic       BUSY,
  input wire logic       CONTINUOUS_MODE,
  input wire logic [1:0] READ_PARAM
);
  import mfr_pkg::*;
  logic       sck_q;
  logic [7:0] rises;
  logic       busy_frame;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // Pin count runs ahead of the synced one, so minimums stay safe
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sck_q <= 1'b0;
      rises <= 8'h00;
    end else begin
      sck_q <= SCK;
      if (CS_N) begin
        rises <= 8'h00;
      end else if (SCK && !sck_q && rises != 8'hFF) begin
        rises <= rises + 8'h01;
      end
    end
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy_frame <= 1'b0;
    end else if (CS_N) begin
      busy_frame <= BUSY;
    end
  end
  property p_busy;
    !CS_N && busy_frame |-> DATA_OE == 4'h0;
  endproperty
  a_busy: assert property (p_busy) else $error("read answered while busy");
  property p_quad;
    DATA_OE == 4'hF |-> QUAD_ENABLE;
  endproperty
  a_quad: assert property (p_quad) else $error("four lines driven without quad enable");
  property p_lanes;
    DATA_OE inside {4'h0, 4'h2, 4'h3, 4'hF};
  endproperty
  a_lanes: assert property (p_lanes) else $error("odd set of driven lines");
  property p_idle;
    CS_N [*5] |-> DATA_OE == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("lines driven while deselected");
  property p_hold;
    $rose(SCK) && DATA_OE != 4'h0 |-> ##1 $stable(DATA_OUT) [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("data moved while clock high");
  property p_lat1;
    !CS_N && DATA_OE == 4'h2 |-> rises >= 8'd40;
  endproperty
  a_lat1: assert property (p_lat1) else $error("serial data too early");
  property p_lat2;
    !CS_N && DATA_OE == 4'h3 |-> rises >= 8'd16;
  endproperty
  a_lat2: assert property (p_lat2) else $error("dual data too early");
  property p_lat4;
    !CS_N && DATA_OE == 4'hF |-> rises >= 8'd12;
  endproperty
  a_lat4: assert property (p_lat4) else $error("quad data too early");
  property p_prm;
    $rose(ARST_N) |-> READ_PARAM == PARAM_DEFAULT;
  endproperty
  a_prm: assert property (p_prm) else $error("read parameter not default");
  property p_mode;
    CS_N [*8] |=> $stable(CONTINUOUS_MODE);
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved between frames");
endmodule : mfr_props
bind mfr_top mfr_props mfr_props_i (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .SCK(SCK), .CS_N(CS_N),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .QUAD_ENABLE(QUAD_ENABLE), .BUSY(BUSY),
  .CONTINUOUS_MODE(CONTINUOUS_MODE), .READ_PARAM(READ_PARAM));
`default_nettype wire

// *** src/mfr_mem.sv ***
/*
  Small read array for the fast read path, registered read data.
  Assumes one read and at most one write per cycle from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module mfr_mem (
  // Clock
  input  wire logic                      clk,
  // Write port
  input  wire mfr_pkg::mfr_load_t        load,
  // Read port
  input  wire logic [mfr_pkg::MEM_AW-1:0] raddr,
  output var  logic [7:0]                rdata
);
  import mfr_pkg::*;
  logic [7:0] mem [0:(1<<MEM_AW)-1];

  always_ff @(posedge clk) begin
    if (load.wr) begin
      mem[load.addr] <= load.data;
    end
    rdata <= mem[raddr];
  end
endmodule : mfr_mem
`default_nettype wire

// *** src/mfr_pkg.sv ***
/*
  Package for the multi-line fast read path: opcodes, counts, pin bundles.
  Assumes a host that drives chip select and a serial clock far below CORE_CLK.
*/
package mfr_pkg;
  localparam logic [7:0] OP_FAST_READ   = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT    = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT    = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO     = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO     = 8'hEB;
  localparam logic [7:0] OP_SET_PARAM   = 8'hC0;
  localparam logic [7:0] OP_RESET_EN    = 8'h66;
  localparam logic [7:0] OP_RESET       = 8'h99;
  localparam int         ADDR_W         = 24;
  localparam int         MEM_AW         = 8;
  localparam logic [5:0] DUMMY_SERIAL   = 6'h08;
  localparam logic [5:0] DUMMY_DUAL_OUT = 6'h08;
  localparam logic [5:0] DUMMY_QUAD_OUT = 6'h08;
  localparam logic [5:0] MODE_CLK_DIO   = 6'h04;
  localparam logic [5:0] MODE_CLK_QIO   = 6'h02;
  localparam logic [5:0] DUMMY_QIO      = 6'h04;
  localparam logic [1:0] PARAM_DEFAULT  = 2'h0;
  localparam int         PARAM_LSB      = 4;
  localparam logic [1:0] MODE_KEEP      = 2'h2;
  localparam int         MODE_SEL_LSB   = 4;
  localparam logic [5:0] OPC_BITS       = 6'h08;
  localparam logic [5:0] ADDR_BITS      = 6'h18;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } mfr_pins_t;

  typedef struct packed {
    logic             wr;
    logic [MEM_AW-1:0] addr;
    logic [7:0]       data;
  } mfr_load_t;
endpackage : mfr_pkg

// *** src/mfr_top.sv ***
/*
  Device side read path of a serial NOR flash: single, dual and quad fast reads,
  continuous read mode, four-wire command mode with programmable dummy count.
  Assumes SCK, CS_N and data pins are asynchronous to CORE_CLK and at least
  eight times slower; they are synchronised and edge detected here.
*/
// Behaviour
// - Fast read 0Bh accepted in four-wire command mode and serial mode.
// - Four-wire dummy count from parameter bits 5:4: 4,4,6,8 cycles.
// - Dummy parameter resets to 4 cycles at power-up and reset instruction.
// - Dual output read drives data on serial-out and serial-in lines.
// - Dual output read waits eight ignored dummy clocks after 24-bit address.
// - Quad output read refused unless quad enable set; drives four lines.
// - Quad output dummy clocks ignored; host floats lines before data.
// - Dual I/O address enters two bits per clock on lines zero, one.
// - Dual I/O mode byte follows address; its bits 5:4 set next opcode skip.
// - Lower mode nibble ignored; host may leave those cycles undriven.
// - Software reset sequence leaves continuous mode state unchanged.
// - Quad I/O address and data use four lines; dummies precede data.
// - Quad I/O read executes only with quad enable set; continuous mode frames skip the enable check.
// - Mode select bits 10 make next command begin directly with address.
// - Other select bits demand full opcode on next command.
// - Serial fast read needs eight ignored dummy clocks after address.
// - Data shifted MSB first on falling edge; input sampled on rising.
// - Read address increments after each byte until chip select rises.
// - Read commands ignored while busy with erase, program or write; continuous mode frames skip the busy check.
`timescale 1ns/1ps
`default_nettype none
module mfr_top (
  // Clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   ARST_N,
  // Serial link
  input  wire logic                   SCK,
  input  wire logic                   CS_N,
  input  wire logic [3:0]             DATA_IN,
  output var  logic [3:0]             DATA_OUT,
  output var  logic [3:0]             DATA_OE,
  // Configuration and status
  input  wire logic                   QUAD_ENABLE,
  input  wire logic                   FOUR_WIRE_MODE,
  input  wire logic                   BUSY,
  // Array load
  input  wire mfr_pkg::mfr_load_t     LOAD,
  // Status out
  output var  logic                   CONTINUOUS_MODE,
  output var  logic [1:0]             READ_PARAM
);
  import mfr_pkg::*;

  typedef enum {S_IDLE, S_OPC, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_PARAM, S_IGNORE} mfr_state_t;
  typedef enum {W_ONE, W_TWO, W_FOUR} mfr_width_t;

  logic [1:0] sck_s, cs_s;
  logic [3:0] din_a, din_s;
  logic       sck_d;
  logic       rise, fall, cs_hi;
  mfr_state_t state;
  mfr_width_t in_w, out_w;
  logic [5:0]  cnt;
  logic [7:0]  shreg;
  logic [ADDR_W-1:0] addr;
  logic [7:0]  mode_byte;
  logic [7:0]  opcode;
  logic        reset_armed;
  logic [5:0]  dummy_n;
  logic [5:0]  mode_n;
  logic [7:0]  rdata;
  logic [7:0]  obyte;
  logic [2:0]  obit;
  logic [3:0]  lanes;
  // Two-entry buffer between array read and shifter
  logic [7:0]  buf_q [0:1];
  logic        buf_wp, buf_rp;
  logic [1:0]  buf_cnt;
  logic        buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  logic        fetch_pend;

  function automatic logic [5:0] bits_per_clk(input mfr_width_t w);
    case (w)
      W_TWO:   bits_per_clk = 6'h02;
      W_FOUR:  bits_per_clk = 6'h04;
      default: bits_per_clk = 6'h01;
    endcase
  endfunction

  function automatic logic [5:0] qpi_dummy(input logic [1:0] p);
    case (p)
      2'h2:    qpi_dummy = 6'h06;
      2'h3:    qpi_dummy = 6'h08;
      default: qpi_dummy = 6'h04;
    endcase
  endfunction

  // Synchronisers: first stage feeds only the second
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sck_s <= 2'h0;
      cs_s  <= 2'h3;
      din_a <= 4'h0;
      din_s <= 4'h0;
      sck_d <= 1'b0;
    end else begin
      sck_s <= {sck_s[0], SCK};
      cs_s  <= {cs_s[0], CS_N};
      din_a <= DATA_IN;
      din_s <= din_a;
      sck_d <= sck_s[1];
    end
  end

  assign cs_hi = cs_s[1];
  assign rise  = !cs_hi && sck_s[1] && !sck_d;
  assign fall  = !cs_hi && !sck_s[1] && sck_d;

  // Sampled input bits for the current width, MSB first
  logic [3:0] in_bits;
  always_comb begin
    case (in_w)
      W_TWO:   in_bits = {2'h0, din_s[1:0]};
      W_FOUR:  in_bits = din_s;
      default: in_bits = {3'h0, din_s[0]};
    endcase
  end

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] b, input mfr_width_t w);
    case (w)
      W_TWO:   shift_in = {s[5:0], b[1:0]};
      W_FOUR:  shift_in = {s[3:0], b};
      default: shift_in = {s[6:0], b[0]};
    endcase
  endfunction

  // Command sequencer
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state           <= S_IDLE;
      in_w            <= W_ONE;
      out_w           <= W_ONE;
      cnt             <= 6'h00;
      shreg           <= 8'h00;
      addr            <= '0;
      mode_byte       <= 8'h00;
      opcode          <= 8'h00;
      reset_armed     <= 1'b0;
      READ_PARAM      <= PARAM_DEFAULT;
      CONTINUOUS_MODE <= 1'b0;
      dummy_n         <= 6'h00;
      mode_n          <= 6'h00;
    end else if (cs_hi) begin
      state <= S_IDLE;
      cnt   <= 6'h00;
    end else begin
      case (state)
        S_IDLE: begin
          in_w  <= FOUR_WIRE_MODE ? W_FOUR : W_ONE;
          cnt   <= 6'h00;
          if (CONTINUOUS_MODE) begin
            // Previous mode bits kept opcode skip armed
            // Opcode of the arming read is kept, so the width and mode length follow it
            state  <= S_ADDR;
            in_w   <= (opcode == OP_DUAL_IO) ? W_TWO : W_FOUR;
          end else begin
            state <= S_OPC;
          end
        end
        S_OPC: if (rise) begin
          shreg <= shift_in(shreg, in_bits, in_w);
          cnt   <= cnt + bits_per_clk(in_w);
          if (cnt + bits_per_clk(in_w) == OPC_BITS) begin
            cnt    <= 6'h00;
            opcode <= shift_in(shreg, in_bits, in_w);
            state  <= S_ADDR;
            // Enable must be the opcode of the frame just before; continuous mode untouched
            reset_armed <= (shift_in(shreg, in_bits, in_w) == OP_RESET_EN);
            if (reset_armed && shift_in(shreg, in_bits, in_w) == OP_RESET) READ_PARAM <= PARAM_DEFAULT;
            case (shift_in(shreg, in_bits, in_w))
              OP_FAST_READ: begin
                dummy_n <= FOUR_WIRE_MODE ? qpi_dummy(READ_PARAM) : DUMMY_SERIAL;
                out_w   <= FOUR_WIRE_MODE ? W_FOUR : W_ONE;
              end
              OP_DUAL_OUT: begin
                dummy_n <= DUMMY_DUAL_OUT;
                out_w   <= W_TWO;
              end
              OP_QUAD_OUT: begin
                dummy_n <= DUMMY_QUAD_OUT;
                out_w   <= W_FOUR;
                if (!QUAD_ENABLE) state <= S_IGNORE;
              end
              OP_DUAL_IO: begin
                in_w  <= W_TWO;
                out_w <= W_TWO;
              end
              OP_QUAD_IO: begin
                in_w  <= W_FOUR;
                out_w <= W_FOUR;
                if (!QUAD_ENABLE) state <= S_IGNORE;
              end
              OP_SET_PARAM: state <= S_PARAM;
              default: state <= S_IGNORE;
            endcase
            if (BUSY && shift_in(shreg, in_bits, in_w) != OP_SET_PARAM) state <= S_IGNORE;
          end
        end
        S_ADDR: if (rise) begin
          if (in_w == W_TWO) addr <= {addr[ADDR_W-3:0], in_bits[1:0]};
          else if (in_w == W_FOUR) addr <= {addr[ADDR_W-5:0], in_bits};
          else addr <= {addr[ADDR_W-2:0], in_bits[0]};
          cnt <= cnt + bits_per_clk(in_w);
          if (cnt + bits_per_clk(in_w) == ADDR_BITS) begin
            cnt <= 6'h00;
            if (opcode == OP_DUAL_IO) begin
              mode_n <= MODE_CLK_DIO;
              state  <= S_MODE;
            end else if (opcode == OP_QUAD_IO) begin
              mode_n  <= MODE_CLK_QIO;
              dummy_n <= FOUR_WIRE_MODE ? qpi_dummy(READ_PARAM) - MODE_CLK_QIO : DUMMY_QIO;
              state   <= S_MODE;
            end else begin
              state <= S_DUMMY;
            end
          end
        end
        S_MODE: if (rise) begin
          mode_byte <= shift_in(mode_byte, in_bits, in_w);
          cnt       <= cnt + 6'h01;
          if (cnt + 6'h01 == mode_n) begin
            cnt <= 6'h00;
            // Only mode bits 5:4 count; bits 7:6 and the lower nibble are don't care
            CONTINUOUS_MODE <= 2'(shift_in(mode_byte, in_bits, in_w) >> MODE_SEL_LSB) == MODE_KEEP;
            state <= (opcode == OP_QUAD_IO && dummy_n != 6'h00) ? S_DUMMY : S_DATA;
          end
        end
        S_DUMMY: if (rise) begin
          cnt <= cnt + 6'h01;
          if (cnt + 6'h01 == dummy_n) state <= S_DATA;
        end
        S_PARAM: if (rise) begin
          shreg <= shift_in(shreg, in_bits, in_w);
          cnt   <= cnt + bits_per_clk(in_w);
          if (cnt + bits_per_clk(in_w) == OPC_BITS) begin
            READ_PARAM <= 2'(shift_in(shreg, in_bits, in_w) >> PARAM_LSB);
            state      <= S_IGNORE;
          end
        end
        S_DATA:   state <= S_DATA;
        S_IGNORE: state <= S_IGNORE;
        default:  state <= S_IDLE;
      endcase
    end
  end

  // Array fetch into the two-entry buffer, address increments per byte
  assign buf_in_ready  = (buf_cnt != 2'h2) && !fetch_pend;
  assign buf_in_valid  = (state == S_DATA) && buf_in_ready;
  assign buf_out_valid = (buf_cnt != 2'h0);

  logic [ADDR_W-1:0] rd_addr;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_addr    <= '0;
      fetch_pend <= 1'b0;
      buf_wp     <= 1'b0;
      buf_rp     <= 1'b0;
      buf_cnt    <= 2'h0;
      buf_q[0]   <= 8'h00;
      buf_q[1]   <= 8'h00;
    end else if (state != S_DATA) begin
      rd_addr    <= addr;
      fetch_pend <= 1'b0;
      buf_wp     <= 1'b0;
      buf_rp     <= 1'b0;
      buf_cnt    <= 2'h0;
    end else begin
      fetch_pend <= buf_in_valid;
      if (buf_in_valid) rd_addr <= rd_addr + 1'b1;
      if (fetch_pend) begin
        buf_q[buf_wp] <= rdata;
        buf_wp        <= !buf_wp;
      end
      if (buf_out_ready && buf_out_valid) buf_rp <= !buf_rp;
      buf_cnt <= buf_cnt + {1'b0, fetch_pend} - {1'b0, buf_out_ready && buf_out_valid};
    end
  end

  mfr_mem u_mem (
    .clk   (CORE_CLK),
    .load  (LOAD),
    .raddr (rd_addr[MEM_AW-1:0]),
    .rdata (rdata)
  );

  // Output shifter: MSB first on falling edges
  assign buf_out_ready = (state == S_DATA) && fall && (obit == 3'h0);
  always_comb begin
    case (out_w)
      W_TWO:   lanes = 4'h3;
      W_FOUR:  lanes = 4'hF;
      default: lanes = 4'h2;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      obyte      <= 8'h00;
      obit       <= 3'h0;
      DATA_OUT   <= 4'h0;
      DATA_OE    <= 4'h0;
    end else if (state != S_DATA || cs_hi) begin
      obit       <= 3'h0;
      DATA_OE    <= 4'h0;
    end else if (fall) begin
      DATA_OE    <= lanes;
      if (obit == 3'h0) begin
        obyte <= buf_q[buf_rp];
        case (out_w)
          W_TWO:   begin DATA_OUT <= {2'h0, buf_q[buf_rp][7:6]}; obyte <= {buf_q[buf_rp][5:0], 2'h0}; obit <= 3'h3; end
          W_FOUR:  begin DATA_OUT <= buf_q[buf_rp][7:4]; obyte <= {buf_q[buf_rp][3:0], 4'h0}; obit <= 3'h1; end
          default: begin DATA_OUT <= {2'h0, buf_q[buf_rp][7], 1'b0}; obyte <= {buf_q[buf_rp][6:0], 1'b0}; obit <= 3'h7; end
        endcase
      end else begin
        obit <= obit - 3'h1;
        case (out_w)
          W_TWO:   begin DATA_OUT <= {2'h0, obyte[7:6]}; obyte <= {obyte[5:0], 2'h0}; end
          W_FOUR:  begin DATA_OUT <= obyte[7:4]; obyte <= {obyte[3:0], 4'h0}; end
          default: begin DATA_OUT <= {2'h0, obyte[7], 1'b0}; obyte <= {obyte[6:0], 1'b0}; end
        endcase
      end
    end
  end
endmodule : mfr_top
`default_nettype wire
